/* arinc_rx_spi_pkg.sv */
// Shared constants and types for the serial command decoder of the receiver.
package arinc_rx_spi_pkg;

    // Op codes carried in the first serial byte.
    localparam logic [7:0] OP_NONE = 8'h00;
    localparam logic [7:0] OP_MASTER_RESET = 8'h01;
    localparam logic [7:0] OP_CLEAR_ALL = 8'h02;
    localparam logic [7:0] OP_SET_ALL = 8'h03;
    localparam logic [7:0] OP_CLEAR_ONE = 8'h04;
    localparam logic [7:0] OP_SET_ONE = 8'h05;
    localparam logic [7:0] OP_WRITE_TABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DIV = 8'h07;
    localparam logic [7:0] OP_READ_FIFO = 8'h08;
    localparam logic [7:0] OP_READ_CTRL = 8'h0B;
    localparam logic [7:0] OP_READ_DIV = 8'h0C;
    localparam logic [7:0] OP_READ_TABLE = 8'h0D;
    localparam logic [7:0] OP_WRITE_CTRL = 8'h10;

    // Field lengths in bits, label count and FIFO depth in words.
    localparam int OPCODE_BITS = 8;
    localparam logic [8:0] LEN_BYTE = 9'h008;
    localparam logic [8:0] LEN_CTRL = 9'h010;
    localparam logic [8:0] LEN_TABLE = 9'h100;
    localparam int WORD_BITS = 32;
    localparam int CTRL_BITS = 16;
    localparam int LABELS = 256;
    localparam int RX_FIFO_DEPTH = 32;

    // Positions of control bits used by this block.
    localparam int CTRL_CLK_SOURCE_SELECT = 1;
    localparam int CTRL_LABEL_RECOGNITION = 2;
    localparam int CTRL_FLAG_POLARITY_SELECT = 15;

    // Values after reset.
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [7:0] DIV_RESET = 8'h01;
    localparam logic [255:0] LABEL_RESET = '0;

    // Legal divide values for the timing clock.
    localparam logic [7:0] DIV_1 = 8'h01;
    localparam logic [7:0] DIV_2 = 8'h02;
    localparam logic [7:0] DIV_4 = 8'h04;
    localparam logic [7:0] DIV_8 = 8'h08;
    localparam logic [7:0] DIV_10 = 8'h0A;

    // Serial engine states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_OPCODE = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_READ = 4'b1000
    } spi_state_t;

endpackage

/* arinc_rx_fifo.sv */
// Synchronous word FIFO with valid/ready on both sides and a flush input.
`timescale 1ns/1ps
`default_nettype none
module arinc_rx_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    // Filling side.
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    // Draining side.
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready,
    // Level.
    output logic o_full,
    output logic o_empty
);
    localparam int AW = $clog2(DEPTH);

    // Storage and pointers; the extra pointer bit tells full from empty.
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire push = i_valid && o_ready;
    wire pop = o_valid && i_ready;

    assign o_empty = (wr_ptr == rd_ptr);
    assign o_full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign o_ready = !o_full;
    assign o_valid = !o_empty;
    assign o_data = mem[rd_ptr[AW-1:0]];

    // Pointer update; a flush discards everything held.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (i_flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Storage write; no reset is needed on the array.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= i_data;
        end
    end
endmodule
`default_nettype wire

/* arinc_rx_spi_command_decoder.sv */
// Serial command decoder, label table, clock divider and receive FIFO of the receiver.
// Operation
// - Master reset pulse empties FIFO, clears flags.
// - Shifting happens only while chip select low.
// - Flag shows empty or full per polarity.
// - Eight opcode bits, MSB first, rising edges.
// - Write data follows opcode directly, MSB first.
// - Control write 16 bits, table 256 bits.
// - Read MSB out at next falling edge.
// - Set and reset act at final bit.
// - Opcode 00 does nothing.
// - Opcode 01 acts as master reset.
// - Opcode 02 clears every label entry.
// - Opcode 03 sets every label entry.
// - Opcode 04 clears one addressed label.
// - Opcode 05 sets one addressed label.
// - Opcode 06 writes all labels from FF down.
// - Opcode 07 divide; bad values stop clock.
// - Source select picks divided timing clock.
// - Independent enable for each of 256 labels.
// - FIFO holds 32 words of 32 bits.
// - Bit timing comes from 1 MHz enable.
// - Opcode 08 reads FIFO word or zeros.
// - Opcode 0C reads back divide value.
// - Opcode 10 writes, 0B reads control.
// - Opcode 0D reads labels from FF down.
`timescale 1ns/1ps
`default_nettype none
module arinc_rx_spi_command_decoder
    import arinc_rx_spi_pkg::*;
#(
    parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    // Pins from the host.
    input wire logic I_MASTER_RESET_IN,
    input wire logic I_SPI_CS_N,
    input wire logic I_SPI_SCK,
    input wire logic I_SPI_SI,
    input wire logic I_ACLK,
    // Pins to the host.
    output logic O_SPI_SO,
    output logic O_FIFO_LEVEL_FLAG,
    // Received words from the bit decoder.
    input wire logic [31:0] I_RX_WORD,
    input wire logic I_RX_VALID,
    output logic O_RX_READY,
    // Label lookup for the bit decoder.
    input wire logic [7:0] I_RX_LABEL,
    output logic O_LABEL_ACCEPT,
    // Configuration and timing to the bit decoder.
    output logic [15:0] O_CONTROL_WORD,
    output logic O_ARINC_CLK_EN
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [1:0] cs_sync; // Chip select, idles high.
    logic [1:0] sck_sync; // Serial clock.
    logic [1:0] si_sync; // Serial data in.
    logic [1:0] mr_sync; // Master reset pin.
    logic [1:0] aclk_sync; // Timing clock pin.
    logic sck_prev; // Last synchronised serial clock level.
    logic aclk_prev; // Last synchronised timing clock level.

    // Two flip-flops per pin; only the second stage is read by logic.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            cs_sync <= 2'b11;
            sck_sync <= 2'b00;
            si_sync <= 2'b00;
            mr_sync <= 2'b00;
            aclk_sync <= 2'b00;
            sck_prev <= 1'b0;
            aclk_prev <= 1'b0;
        end else begin
            cs_sync <= {cs_sync[0], I_SPI_CS_N};
            sck_sync <= {sck_sync[0], I_SPI_SCK};
            si_sync <= {si_sync[0], I_SPI_SI};
            mr_sync <= {mr_sync[0], I_MASTER_RESET_IN};
            aclk_sync <= {aclk_sync[0], I_ACLK};
            sck_prev <= sck_sync[1];
            aclk_prev <= aclk_sync[1];
        end
    end

    wire cs_n = cs_sync[1]; // Chip select after synchronisation.
    wire si = si_sync[1]; // Serial data after synchronisation.
    wire mr = mr_sync[1]; // Master reset after synchronisation.
    wire sck_rise = sck_sync[1] && !sck_prev; // Serial clock rising edge.
    wire sck_fall = !sck_sync[1] && sck_prev; // Serial clock falling edge.
    wire aclk_rise = aclk_sync[1] && !aclk_prev; // Timing clock rising edge.

    ////////////////////////////////////////////////////////////////////////////////
    // Serial engine state and decode.

    spi_state_t state; // Engine state.
    logic [7:0] opcode; // Op code bits received so far.
    logic [8:0] bit_cnt; // Bits counted in the current field.
    logic [8:0] wr_len; // Length of the pending write field.
    logic [255:0] shreg; // Shared shift register for reads and writes.
    logic [15:0] ctrl; // Control register.
    logic [7:0] div_val; // Timing clock divide value.
    logic [255:0] label_en; // Label enable table, bit n is label n.

    // Op code as it stands once the current bit is shifted in.
    wire [7:0] next_opcode = {opcode[6:0], si};
    // Eighth op code bit taken on this edge.
    wire op_done = !cs_n && (state == ST_OPCODE) && sck_rise && (bit_cnt == 9'(OPCODE_BITS - 1));
    // Last bit of a write field taken on this edge.
    wire wr_done = !cs_n && (state == ST_WRITE) && sck_rise && (bit_cnt == wr_len - 9'h001);
    // Write field this op code takes, zero when none.
    wire [8:0] next_wr_len =
        (next_opcode == OP_CLEAR_ONE || next_opcode == OP_SET_ONE ||
         next_opcode == OP_WRITE_DIV) ? LEN_BYTE :
        (next_opcode == OP_WRITE_CTRL) ? LEN_CTRL :
        (next_opcode == OP_WRITE_TABLE) ? LEN_TABLE : 9'h000;
    // Read op codes.
    wire is_read = (next_opcode == OP_READ_FIFO) || (next_opcode == OP_READ_CTRL) ||
        (next_opcode == OP_READ_DIV) || (next_opcode == OP_READ_TABLE);

    // FIFO side signals.
    logic [31:0] fifo_data; // Head word of the FIFO.
    logic fifo_valid; // FIFO holds a word.
    logic fifo_full; // FIFO full.
    logic fifo_empty; // FIFO empty.

    // Read data, most significant bit at the top of the shift register.
    wire [31:0] fifo_word = fifo_valid ? fifo_data : 32'h0000_0000;
    wire [255:0] read_val =
        (next_opcode == OP_READ_FIFO) ? {fifo_word, 224'h0} :
        (next_opcode == OP_READ_CTRL) ? {ctrl, 240'h0} :
        (next_opcode == OP_READ_DIV) ? {div_val, 248'h0} :
        label_en;

    // Instruction actions.
    wire do_master_reset = op_done && (next_opcode == OP_MASTER_RESET);
    wire do_clear_all = op_done && (next_opcode == OP_CLEAR_ALL);
    wire do_set_all = op_done && (next_opcode == OP_SET_ALL);
    wire do_pop = op_done && (next_opcode == OP_READ_FIFO) && fifo_valid;
    wire [255:0] wr_field = {shreg[254:0], si}; // Write field including its last bit.
    wire fifo_flush = mr || do_master_reset;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial engine.

    // The engine runs only while chip select is low; a rise returns it to idle
    // and an unfinished op code or write field is dropped without effect.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            state <= ST_IDLE;
            opcode <= 8'h00;
            bit_cnt <= 9'h000;
            wr_len <= 9'h000;
        end else if (cs_n) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // Chip select has fallen; wait for the first op code bit.
                    state <= ST_OPCODE;
                    bit_cnt <= 9'h000;
                end
                ST_OPCODE: begin
                    if (sck_rise) begin
                        opcode <= next_opcode;
                        bit_cnt <= bit_cnt + 9'h001;
                        if (op_done) begin
                            bit_cnt <= 9'h000;
                            wr_len <= next_wr_len;
                            // Unimplemented codes, op code 00 among them, just idle on.
                            if (next_wr_len != 9'h000) begin
                                state <= ST_WRITE;
                            end else if (is_read) begin
                                state <= ST_READ;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_WRITE: begin
                    if (sck_rise) begin
                        bit_cnt <= bit_cnt + 9'h001;
                        if (wr_done) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_READ: begin
                    // Reads end when chip select rises.
                    state <= ST_READ;
                end
            endcase
        end
    end

    // Shift register: loads read data after the op code, shifts out on falling
    // edges while reading and shifts in on rising edges while writing.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            shreg <= '0;
            O_SPI_SO <= 1'b0;
        end else if (cs_n) begin
            O_SPI_SO <= 1'b0;
        end else if (op_done && is_read) begin
            shreg <= read_val;
        end else if (state == ST_READ && sck_fall) begin
            O_SPI_SO <= shreg[255];
            shreg <= {shreg[254:0], 1'b0};
        end else if (state == ST_WRITE && sck_rise) begin
            shreg <= wr_field;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers set by instructions.

    // Control word and divide value change only when their field completes.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            ctrl <= CTRL_RESET;
            div_val <= DIV_RESET;
        end else if (wr_done) begin
            if (opcode == OP_WRITE_CTRL) begin
                ctrl <= wr_field[15:0];
            end
            if (opcode == OP_WRITE_DIV) begin
                div_val <= wr_field[7:0];
            end
        end
    end

    // Label table; clear-all and set-all codes act right after the eighth op code bit.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            label_en <= LABEL_RESET;
        end else if (do_clear_all) begin
            label_en <= '0;
        end else if (do_set_all) begin
            label_en <= '1;
        end else if (wr_done && opcode == OP_CLEAR_ONE) begin
            label_en[wr_field[7:0]] <= 1'b0;
        end else if (wr_done && opcode == OP_SET_ONE) begin
            label_en[wr_field[7:0]] <= 1'b1;
        end else if (wr_done && opcode == OP_WRITE_TABLE) begin
            label_en <= wr_field;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timing clock divider.

    logic [7:0] div_cnt; // Timing clock edges counted toward one tick.
    wire div_valid = (div_val == DIV_1) || (div_val == DIV_2) || (div_val == DIV_4) ||
        (div_val == DIV_8) || (div_val == DIV_10);
    wire div_tick = div_valid && aclk_rise && (div_cnt == div_val - 8'h01);
    wire ctrl_src = ctrl[CTRL_CLK_SOURCE_SELECT];
    wire next_clk_en = ctrl_src ? div_tick : aclk_rise;

    // Count timing clock edges; an illegal value holds the counter at zero.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            div_cnt <= 8'h00;
        end else if (!div_valid || div_tick) begin
            div_cnt <= 8'h00;
        end else if (aclk_rise) begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive FIFO and registered outputs.

    // Depth set for 32 words of 32 bits.
    arinc_rx_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_flush(fifo_flush),
        .i_data(I_RX_WORD),
        .i_valid(I_RX_VALID),
        .o_ready(),
        .o_data(fifo_data),
        .o_valid(fifo_valid),
        .i_ready(do_pop),
        .o_full(fifo_full),
        .o_empty(fifo_empty)
    );

    // Outputs are all registered; the ready tracks the FIFO one cycle late, so
    // the source must only push when it also sees ready, and full refuses.
    wire next_flag = ctrl[CTRL_FLAG_POLARITY_SELECT] ? fifo_full : fifo_empty;
    wire next_accept = !ctrl[CTRL_LABEL_RECOGNITION] || label_en[I_RX_LABEL];
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_FIFO_LEVEL_FLAG <= 1'b0;
            O_RX_READY <= 1'b0;
            O_LABEL_ACCEPT <= 1'b0;
            O_CONTROL_WORD <= CTRL_RESET;
            O_ARINC_CLK_EN <= 1'b0;
        end else begin
            O_FIFO_LEVEL_FLAG <= next_flag;
            O_RX_READY <= !fifo_full && !fifo_flush;
            O_LABEL_ACCEPT <= next_accept;
            O_CONTROL_WORD <= ctrl;
            O_ARINC_CLK_EN <= next_clk_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence s_opcode_taken(logic [7:0] op);
        op_done && next_opcode == op;
    endsequence

    a_mr_flush: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        mr |=> fifo_empty) else $error("FIFO not empty after master reset.");

    a_flag_polarity: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        1'b1 |=> O_FIFO_LEVEL_FLAG == ($past(ctrl[CTRL_FLAG_POLARITY_SELECT]) ?
        $past(fifo_full) : $past(fifo_empty)))
        else $error("Level flag wrong for polarity.");

    a_cs_idle: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        cs_n |=> state == ST_IDLE && O_SPI_SO == 1'b0)
        else $error("Engine active with chip select high.");

    a_opcode_length: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        op_done |=> state != ST_OPCODE && bit_cnt == 9'h000)
        else $error("Op code did not end after eight bits.");

    a_clear_all: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        s_opcode_taken(OP_CLEAR_ALL) |=> label_en == '0)
        else $error("Table not cleared.");

    a_set_all: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        s_opcode_taken(OP_SET_ALL) |=> label_en == '1)
        else $error("Table not set.");

    a_div_invalid: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        ctrl_src && !div_valid |=> !O_ARINC_CLK_EN)
        else $error("Clock runs with illegal divide.");

    a_read_empty: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        s_opcode_taken(OP_READ_FIFO) and fifo_empty |=> shreg[255:224] == 32'h0000_0000)
        else $error("Empty FIFO read not zero.");

    a_direct_clock: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        !ctrl_src && aclk_rise |=> O_ARINC_CLK_EN)
        else $error("Direct timing edge lost.");

    a_abandon: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        state == ST_WRITE && cs_n |=> $stable(ctrl) && $stable(label_en))
        else $error("Aborted write changed state.");
endmodule
`default_nettype wire

/* spi_host_model.sv */
// Behavioural serial host that drives chip select, clock and data into the decoder.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // Clock of the system, used only to pace the pins.
    input wire logic i_clk,
    // Pins towards the decoder.
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si,
    // Pin from the decoder.
    input wire logic i_so
);
    // Idle pins rest at their pulled levels so nothing is left floating.
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
    end
    // Waits whole cycles and then steps just past the edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // One frame: op code, then n field bits, MSB first; sel low keeps chip select high.
    task automatic xfer(input logic [7:0] op, input int n, input logic [255:0] d,
                        input logic sel, output logic [255:0] q);
        q = '0;
        o_cs_n = !sel;
        cyc(6);
        for (int i = 0; i < n + 8; i++) begin
            o_si = (i < 8) ? op[7 - i] : d[n + 7 - i];
            cyc(6);
            // Read data is taken at the end of the low phase, after the falling edge.
            if (i >= 8) begin
                q = {q[254:0], i_so};
            end
            o_sck = 1'b1;
            cyc(6);
            o_sck = 1'b0;
        end
        cyc(6);
        // Released data goes to its pull-down level, and select stays high for a while.
        o_cs_n = 1'b1;
        o_si = 1'b0;
        cyc(6);
    endtask
endmodule
`default_nettype wire

/* arinc_rx_spi_command_decoder_bench.sv */
// Self-checking bench of the serial command decoder against a queue-based model.
`timescale 1ns/1ps
`default_nettype none
module arinc_rx_spi_command_decoder_bench;
    import arinc_rx_spi_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mr = 1'b0;
    logic aclk = 1'b0;
    logic cs_n, sck, si, so, flag, rx_ready, accept, clk_en;
    logic rx_valid = 1'b0;
    logic [31:0] rx_word = 32'h0000_0000;
    logic [7:0] rx_label = 8'h00;
    logic [15:0] ctrl_word;
    // Model state: control, label table and the FIFO contents.
    logic [15:0] ctrl = 16'h0000;
    logic [255:0] tbl = '0;
    logic [255:0] rd;
    logic [31:0] fifo[$];
    logic [31:0] seed = 32'h0000_157a;
    int error_cnt = 0;
    int checks_done = 0;
    int dvs[7] = '{1, 2, 4, 8, 10, 3, 0};
    logic [7:0] l;
    ////////////////////////////////////////////////////////////////////////////////
    always #4 clk = ~clk;
    // The timing clock runs at a tenth of the system rate.
    initial forever begin
        repeat (5) @(posedge clk);
        #1 aclk = ~aclk;
    end
    spi_host_model u_host (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so));
    arinc_rx_spi_command_decoder u_dut (.I_CLK_SYS(clk), .I_RST(rst),
        .I_MASTER_RESET_IN(mr), .I_SPI_CS_N(cs_n), .I_SPI_SCK(sck), .I_SPI_SI(si),
        .I_ACLK(aclk), .O_SPI_SO(so), .O_FIFO_LEVEL_FLAG(flag), .I_RX_WORD(rx_word),
        .I_RX_VALID(rx_valid), .O_RX_READY(rx_ready), .I_RX_LABEL(rx_label),
        .O_LABEL_ACCEPT(accept), .O_CONTROL_WORD(ctrl_word), .O_ARINC_CLK_EN(clk_en));
    ////////////////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_cnt(input string nm, input int e, input int g);
        checks_done++;
        if (g < e - 1 || g > e + 1) begin
            error_cnt++;
            $display("unexpected %s: expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic op(input logic [7:0] c, input int n, input logic [255:0] d);
        u_host.xfer(c, n, d, 1'b1, rd);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] c, input int n,
                          input logic [255:0] e);
        op(c, n, '0);
        chk(nm, e, rd);
    endtask
    task automatic wr_ctrl(input logic [15:0] v);
        op(OP_WRITE_CTRL, 16, 256'(v));
        ctrl = v;
        cyc(3);
        chk("control word", 256'(ctrl), 256'(ctrl_word));
    endtask
    // Flag and ready follow the FIFO fill level one cycle late.
    task automatic pins();
        cyc(3);
        chk_bit("flag", ctrl[15] ? fifo.size() == 32 : fifo.size() == 0, flag);
        chk_bit("ready", fifo.size() < 32, rx_ready);
    endtask
    task automatic lbl_chk();
        for (int i = 0; i < 12; i++) begin
            rx_label = 8'(rnd());
            cyc(2);
            chk_bit("label accept", !ctrl[2] || tbl[rx_label], accept);
        end
    endtask
    // Pushes k words; the source sometimes stalls, and never pushes past full.
    task automatic push(input int k);
        for (int i = 0; i < k; i++) begin
            if (i > 0 && rnd() % 2) begin
                rx_valid = 1'b0;
                cyc(2);
            end
            rx_word = rnd();
            rx_valid = 1'b1;
            for (int t = 0; t < 50 && rx_ready !== 1'b1; t++) cyc(1);
            cyc(1);
            fifo.push_back(rx_word);
        end
        rx_valid = 1'b0;
    endtask
    task automatic en_count(input int e);
        int c;
        c = 0;
        repeat (400) begin
            cyc(1);
            c += (clk_en === 1'b1);
        end
        chk_cnt("clock enables", e, c);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // A hang counts as a mismatch and ends the run the ordinary way.
    initial begin
        #400_000;
        error_cnt++;
        end_sim();
    end
    initial begin
        cyc(3);
        rst = 1'b0;
        cyc(4);
        pins();
        rd_chk("control", OP_READ_CTRL, 16, 256'(ctrl));
        rd_chk("divide", OP_READ_DIV, 8, 256'(DIV_RESET));
        rd_chk("fifo word", OP_READ_FIFO, 32, '0);
        wr_ctrl(16'h0004);
        op(OP_WRITE_CTRL, 10, 256'(10'h3ff));
        op(OP_NONE, 8, 256'(8'hff));
        rd_chk("control", OP_READ_CTRL, 16, 256'(ctrl));
        u_host.xfer(OP_SET_ALL, 0, '0, 1'b0, rd);
        lbl_chk();
        op(OP_SET_ALL, 0, '0);
        tbl = '1;
        l = 8'(rnd());
        op(OP_CLEAR_ONE, 8, 256'(l));
        tbl[l] = 1'b0;
        rd_chk("table", OP_READ_TABLE, 256, tbl);
        op(OP_CLEAR_ALL, 0, '0);
        tbl = '0;
        op(OP_SET_ONE, 8, 256'(l));
        tbl[l] = 1'b1;
        rd_chk("table", OP_READ_TABLE, 256, tbl);
        tbl = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        op(OP_WRITE_TABLE, 256, tbl);
        rd_chk("table", OP_READ_TABLE, 256, tbl);
        lbl_chk();
        wr_ctrl(16'h8004);
        pins();
        push(32);
        pins();
        repeat (2) rd_chk("fifo word", OP_READ_FIFO, 32, 256'(fifo.pop_front()));
        pins();
        op(OP_MASTER_RESET, 0, '0);
        fifo.delete();
        rd_chk("fifo word", OP_READ_FIFO, 32, '0);
        push(3);
        mr = 1'b1;
        cyc(3);
        mr = 1'b0;
        fifo.delete();
        wr_ctrl(16'h0000);
        pins();
        lbl_chk();
        rd_chk("fifo word", OP_READ_FIFO, 32, '0);
        en_count(40);
        wr_ctrl(16'h0006);
        foreach (dvs[i]) begin
            op(OP_WRITE_DIV, 8, 256'(dvs[i]));
            rd_chk("divide", OP_READ_DIV, 8, 256'(dvs[i]));
            en_count(dvs[i] inside {1, 2, 4, 8, 10} ? 40 / dvs[i] : 0);
        end
        end_sim();
    end
endmodule
`default_nettype wire
